/* File: inc/anomaly_pkg.sv */
/*
 * Constants for the anomaly alarm manager: register offsets, command codes,
 * horn settings and timing counts.
 * Assumes a 40 MHz system clock.
 */
package anomaly_pkg;
	// ------------------------------------------------------------
	// Registers and commands
	// ------------------------------------------------------------
	localparam logic [15:0] PASSWORD_ENTRY_ADDR = 16'h0065;
	localparam logic [15:0] CODE_ENTRY_ADDR     = 16'h0066;
	localparam logic [15:0] CMD_SILENCE         = 16'h0033; // 51
	localparam logic [15:0] CMD_ACKNOWLEDGE     = 16'h0034; // 52
	// ------------------------------------------------------------
	// Horn duration settings
	// ------------------------------------------------------------
	localparam logic [9:0]  HORN_NEVER          = 10'h000;
	localparam logic [9:0]  HORN_UNTIL_SILENCED = 10'h3e7; // 999
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLOCK_HZ          = 40000000;
	localparam int CMD_WINDOW_S      = 5;
	localparam int CMD_WINDOW_CYCLES = CMD_WINDOW_S * CLOCK_HZ;
	localparam int SECOND_CYCLES     = CLOCK_HZ;
	localparam int FLASH_HALF_MS     = 500;
	localparam int FLASH_HALF_CYCLES = FLASH_HALF_MS * (CLOCK_HZ / 1000);
	// Anomaly classes, one bit each
	localparam int CLS_WARN   = 0;
	localparam int CLS_UNLOAD = 1;
	localparam int CLS_DEACT  = 2;
	localparam int CLS_FAIL   = 3;
endpackage

/* File: core/anomaly_alarm_manager.sv */
/*
 * Anomaly alarm manager: class priority, horn, alarm lamp, breaker and engine
 * stop actions, silence and acknowledge from panel, input and serial link.
 * Assumes the engine sequencer reports ramp completion and honours the stop
 * requests; the serial decoder presents one-cycle holding-register writes.
 */
`timescale 1ns/10ps

module anomaly_alarm_manager #(
	parameter int CMD_WINDOW_CYCLES = anomaly_pkg::CMD_WINDOW_CYCLES,
	parameter int SECOND_CYCLES     = anomaly_pkg::SECOND_CYCLES,
	parameter int FLASH_HALF_CYCLES = anomaly_pkg::FLASH_HALF_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic [3:0]  anomaly_cause,
	input  wire logic        priority_bypass,
	input  wire logic [9:0]  horn_duration,
	input  wire logic [15:0] configured_password,
	input  wire logic        panel_ack_button,
	input  wire logic        alarm_ack_input_function,
	input  wire logic        serial_command_disable_input,
	input  wire logic        reg_write,
	input  wire logic [15:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        unload_ramp_done,
	output logic [3:0]       active_classes,
	output logic [3:0]       unacked_classes,
	output logic             horn,
	output logic             external_horn_output,
	output logic             alarm_lamp,
	output logic             quick_unload_ramp,
	output logic             generator_breaker_open,
	output logic             stop_with_cooling,
	output logic             stop_immediate,
	output logic             restart_inhibit
);
	localparam int W = 4;
	localparam int CW = $clog2(CMD_WINDOW_CYCLES + 1);
	localparam int SW = $clog2(SECOND_CYCLES + 1);
	localparam int FW = $clog2(FLASH_HALF_CYCLES + 1);

	// ------------------------------------------------------------
	// Input synchronisers, three stages, second and third must agree
	// ------------------------------------------------------------
	logic [2:0] btn_sync_reg, btn_sync_next, din_sync_reg, din_sync_next;
	logic [2:0] dis_sync_reg, dis_sync_next;
	logic       btn_state_reg, btn_state_next, din_state_reg, din_state_next;
	logic       dis_state_reg, dis_state_next;
	logic       btn_press, din_rise;

	always_comb begin
		btn_sync_next  = {btn_sync_reg[1:0], panel_ack_button};
		din_sync_next  = {din_sync_reg[1:0], alarm_ack_input_function};
		dis_sync_next  = {dis_sync_reg[1:0], serial_command_disable_input};
		btn_state_next = btn_state_reg;
		din_state_next = din_state_reg;
		dis_state_next = dis_state_reg;
		if (btn_sync_reg[1] == btn_sync_reg[2])
			btn_state_next = btn_sync_reg[2];
		if (din_sync_reg[1] == din_sync_reg[2])
			din_state_next = din_sync_reg[2];
		if (dis_sync_reg[1] == dis_sync_reg[2])
			dis_state_next = dis_sync_reg[2];
		btn_press = btn_state_next & ~btn_state_reg;
		din_rise  = din_state_next & ~din_state_reg;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			btn_sync_reg  <= 3'h0;
			din_sync_reg  <= 3'h0;
			dis_sync_reg  <= 3'h0;
			btn_state_reg <= 1'b0;
			din_state_reg <= 1'b0;
			dis_state_reg <= 1'b0;
		end else begin
			btn_sync_reg  <= btn_sync_next;
			din_sync_reg  <= din_sync_next;
			dis_sync_reg  <= dis_sync_next;
			btn_state_reg <= btn_state_next;
			din_state_reg <= din_state_next;
			dis_state_reg <= dis_state_next;
		end
	end

	// ------------------------------------------------------------
	// Serial password and command sequence
	// ------------------------------------------------------------
	logic          armed_reg, armed_next;
	logic [CW-1:0] win_reg, win_next;
	logic          ser_silence, ser_ack;

	always_comb begin
		armed_next  = armed_reg;
		win_next    = win_reg;
		ser_silence = 1'b0;
		ser_ack     = 1'b0;
		if (armed_reg) begin
			if (win_reg == '0)
				armed_next = 1'b0;
			else
				win_next = win_reg - 1'b1;
		end
		if (reg_write && !dis_state_reg) begin
			if (reg_addr == anomaly_pkg::PASSWORD_ENTRY_ADDR) begin
				armed_next = (reg_wdata == configured_password);
				win_next   = CW'(CMD_WINDOW_CYCLES);
			end else if (reg_addr == anomaly_pkg::CODE_ENTRY_ADDR) begin
				armed_next = 1'b0;
				if (armed_reg && win_reg != '0) begin
					ser_silence = (reg_wdata == anomaly_pkg::CMD_SILENCE);
					ser_ack     = (reg_wdata == anomaly_pkg::CMD_ACKNOWLEDGE);
				end
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			armed_reg <= 1'b0;
			win_reg   <= '0;
		end else begin
			armed_reg <= armed_next;
			win_reg   <= win_next;
		end
	end

	// ------------------------------------------------------------
	// Anomaly acceptance, latching and acknowledge
	// ------------------------------------------------------------
	logic [W-1:0] active_reg, active_next, unack_reg, unack_next;
	logic [W-1:0] accept, new_act;
	logic         silence_req, ack_req;
	logic         horn_reg, horn_next;

	function automatic logic [W-1:0] allowed(input logic [W-1:0] act, input logic bypass);
		logic [W-1:0] a;
		a = '1;
		if (!bypass) begin
			a[anomaly_pkg::CLS_FAIL]   = ~act[3];
			a[anomaly_pkg::CLS_DEACT]  = ~(act[3] | act[2]);
			a[anomaly_pkg::CLS_UNLOAD] = ~(act[3] | act[2] | act[1]);
			a[anomaly_pkg::CLS_WARN]   = ~(act[3] | act[2] | act[1]);
		end
		return a;
	endfunction

	always_comb begin
		// Horn sounding: first panel press only silences
		silence_req = ser_silence | ser_ack | din_rise | btn_press;
		ack_req     = ser_ack | din_rise | (btn_press & ~horn_reg);
		accept      = anomaly_cause & ~active_reg & allowed(active_reg, priority_bypass);
		new_act     = accept;
		active_next = active_reg;
		unack_next  = unack_reg;
		if (ack_req)
			unack_next = '0;
		// Cleared warnings stay listed until acknowledged; higher classes stay listed after it
		for (int i = 0; i < W; i++) begin
			if (active_reg[i] && !unack_next[i] && !anomaly_cause[i]
				&& i == anomaly_pkg::CLS_WARN)
				active_next[i] = 1'b0;
		end
		// Set wins over acknowledge in the same cycle
		active_next = active_next | new_act;
		unack_next  = unack_next | new_act;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			active_reg <= '0;
			unack_reg  <= '0;
		end else begin
			active_reg <= active_next;
			unack_reg  <= unack_next;
		end
	end

	// ------------------------------------------------------------
	// Horn with duration timer
	// ------------------------------------------------------------
	logic [SW-1:0] tick_reg, tick_next;
	logic [9:0]    secs_reg, secs_next;

	always_comb begin
		horn_next = horn_reg;
		tick_next = tick_reg;
		secs_next = secs_reg;
		if (horn_reg) begin
			if (tick_reg == SW'(SECOND_CYCLES - 1)) begin
				tick_next = '0;
				secs_next = secs_reg + 10'h001;
			end else
				tick_next = tick_reg + 1'b1;
			if (horn_duration != anomaly_pkg::HORN_UNTIL_SILENCED
				&& secs_reg >= horn_duration)
				horn_next = 1'b0;
		end
		if (silence_req)
			horn_next = 1'b0;
		if (new_act != '0) begin
			horn_next = (horn_duration != anomaly_pkg::HORN_NEVER);
			tick_next = '0;
			secs_next = 10'h000;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			horn_reg <= 1'b0;
			tick_reg <= '0;
			secs_reg <= 10'h000;
		end else begin
			horn_reg <= horn_next;
			tick_reg <= tick_next;
			secs_reg <= secs_next;
		end
	end

	// ------------------------------------------------------------
	// Lamp flasher and shutdown actions
	// ------------------------------------------------------------
	logic [FW-1:0] flash_cnt_reg, flash_cnt_next;
	logic          flash_reg, flash_next, lamp_next;
	logic          ramp_reg, ramp_next, open_reg, open_next;
	logic          cool_reg, cool_next, imm_reg, imm_next;

	always_comb begin
		flash_cnt_next = flash_cnt_reg + 1'b1;
		flash_next     = flash_reg;
		if (flash_cnt_reg == FW'(FLASH_HALF_CYCLES - 1)) begin
			flash_cnt_next = '0;
			flash_next     = ~flash_reg;
		end
		if (active_reg[3:1] != 3'h0)
			lamp_next = 1'b1;
		else
			lamp_next = active_reg[0] & flash_reg;
		// Warnings never reach these terms
		ramp_next = active_reg[1] & ~unload_ramp_done & ~open_reg;
		open_next = active_reg[3] | active_reg[2] | (active_reg[1] & unload_ramp_done)
			| (open_reg & (active_reg[3:1] != 3'h0));
		imm_next  = active_reg[3];
		cool_next = ~active_reg[3] & (active_reg[2] | (active_reg[1] & open_next));
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			flash_cnt_reg <= '0;
			flash_reg     <= 1'b0;
			alarm_lamp    <= 1'b0;
			ramp_reg      <= 1'b0;
			open_reg      <= 1'b0;
			cool_reg      <= 1'b0;
			imm_reg       <= 1'b0;
		end else begin
			flash_cnt_reg <= flash_cnt_next;
			flash_reg     <= flash_next;
			alarm_lamp    <= lamp_next;
			ramp_reg      <= ramp_next;
			open_reg      <= open_next;
			cool_reg      <= cool_next;
			imm_reg       <= imm_next;
		end
	end

	assign active_classes         = active_reg;
	assign unacked_classes        = unack_reg;
	assign horn                   = horn_reg;
	assign external_horn_output   = horn_reg;
	assign quick_unload_ramp      = ramp_reg;
	assign generator_breaker_open = open_reg;
	assign stop_with_cooling      = cool_reg;
	assign stop_immediate         = imm_reg;
	assign restart_inhibit        = (unack_reg[3:1] != 3'h0);
endmodule // anomaly_alarm_manager

/* File: verification/anomaly_alarm_manager_checker.sv */
/*
 * Concurrent checks on the ports of the anomaly alarm manager.
 * Assumes one clock domain and the bind below.
 */
`timescale 1ns/10ps
module anomaly_alarm_manager_checker (
	input wire logic       clock,
	input wire logic       nrst,
	input wire logic       priority_bypass,
	input wire logic [3:0] active_classes,
	input wire logic       horn,
	input wire logic       external_horn_output,
	input wire logic       alarm_lamp,
	input wire logic       quick_unload_ramp,
	input wire logic       generator_breaker_open,
	input wire logic       stop_with_cooling,
	input wire logic       stop_immediate,
	input wire logic [3:0] unacked_classes,
	input wire logic       restart_inhibit
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// ------------------------------------------------------------
	// Class actions
	// ------------------------------------------------------------
	a_warn_no_trip: assert property (active_classes == 4'h1 |-> !generator_breaker_open
		&& !stop_with_cooling && !stop_immediate) else $error("warning tripped");
	a_unload_ramps: assert property ($rose(active_classes[1]) && active_classes[3:2] == 2'h0
		|=> quick_unload_ramp && !generator_breaker_open) else $error("unload no ramp");
	a_deact_opens: assert property ($rose(active_classes[2]) && !active_classes[3]
		|=> generator_breaker_open && stop_with_cooling) else $error("deact action");
	a_fail_opens: assert property ($rose(active_classes[3]) |=> generator_breaker_open
		&& stop_immediate && !stop_with_cooling) else $error("fail action");
	a_restart_held: assert property (restart_inhibit == (unacked_classes[3:1] != 3'h0))
		else $error("restart inhibit");
	a_trip_inhibits: assert property (active_classes[3:1] != $past(active_classes[3:1])
		|-> restart_inhibit) else $error("restart not inhibited");
	// ------------------------------------------------------------
	// Priority, signalling, latching
	// ------------------------------------------------------------
	a_deact_blocked: assert property (!priority_bypass && active_classes[3]
		&& !active_classes[2] |=> !active_classes[2]) else $error("deact accepted");
	a_warn_blocked: assert property (!priority_bypass && active_classes[3:1] != 3'h0
		&& !active_classes[0] |=> !active_classes[0]) else $error("warning accepted");
	a_ext_horn: assert property (external_horn_output == horn) else $error("ext horn");
	a_lamp_steady: assert property ((active_classes[3:1] != 3'h0) [*2] |-> alarm_lamp)
		else $error("lamp not steady");
	a_class_kept: assert property (active_classes[3:1] != 3'h0 |=>
		(active_classes[3:1] | $past(active_classes[3:1])) == active_classes[3:1])
		else $error("class dropped");
endmodule // anomaly_alarm_manager_checker

bind anomaly_alarm_manager anomaly_alarm_manager_checker chk (.clock, .nrst, .priority_bypass,
	.active_classes, .horn, .external_horn_output, .alarm_lamp, .quick_unload_ramp,
	.generator_breaker_open, .stop_with_cooling, .stop_immediate, .unacked_classes,
	.restart_inhibit);

/* File: verification/serial_master_model.sv */
/*
 * Serial master model: holding-register writes, password then code.
 * Assumes the bench calls its tasks just after a rising edge.
 */
`timescale 1ns/10ps
module serial_master_model (
	input wire logic   clock,
	output logic        reg_write,
	output logic [15:0] reg_addr,
	output logic [15:0] reg_wdata
);
	initial begin
		reg_write = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
	end
	// Released bus shows inverted values, never a stale match
	task automatic put(input logic [15:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_write <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic command(input logic [15:0] pw, input logic [15:0] code, input int gap);
		put(anomaly_pkg::PASSWORD_ENTRY_ADDR, pw);
		repeat (gap) @(posedge clock);
		put(anomaly_pkg::CODE_ENTRY_ADDR, code);
	endtask
endmodule // serial_master_model

/* File: verification/anomaly_alarm_manager_bench.sv */
/*
 * Self-checking bench for the anomaly alarm manager.
 * Assumes short counts: window 200, second 10, flash half 4 cycles.
 */
`timescale 1ns/10ps
module anomaly_alarm_manager_bench;
	logic        clock = 1'b0;
	logic        nrst = 1'b0;
	logic [3:0]  anomaly_cause = 4'h0;
	logic        priority_bypass = 1'b0;
	logic [9:0]  horn_duration = 10'h3e7;
	logic [15:0] configured_password = 16'h5a5a;
	logic        panel_ack_button = 1'b0;
	logic        alarm_ack_input_function = 1'b0;
	logic        serial_command_disable_input = 1'b0;
	logic        unload_ramp_done = 1'b0;
	logic        reg_write, horn, external_horn_output, alarm_lamp, quick_unload_ramp;
	logic        generator_breaker_open, stop_with_cooling, stop_immediate, restart_inhibit;
	logic [15:0] reg_addr, reg_wdata;
	logic [3:0]  active_classes, unacked_classes;
	int          mismatches = 0;
	int          checked = 0;
	logic        lamp0;
	logic [3:0]  lamp_seen;
	// Rows: cause, active, {ramp,open,cool,immediate}, {horn,inhibit}
	logic [15:0] rows [4] = '{16'h1102, 16'h2283, 16'h4463, 16'h8853};
	wire logic [3:0] acts = {quick_unload_ramp, generator_breaker_open, stop_with_cooling,
		stop_immediate};
	wire logic [3:0] snd = {2'h0, horn, restart_inhibit};
	always #12.5 clock = ~clock;
	anomaly_alarm_manager #(.CMD_WINDOW_CYCLES(200), .SECOND_CYCLES(10),
		.FLASH_HALF_CYCLES(4)) uut (.clock, .nrst, .anomaly_cause, .priority_bypass,
		.horn_duration, .configured_password, .panel_ack_button, .alarm_ack_input_function,
		.serial_command_disable_input, .reg_write, .reg_addr, .reg_wdata, .unload_ramp_done,
		.active_classes, .unacked_classes, .horn, .external_horn_output, .alarm_lamp,
		.quick_unload_ramp, .generator_breaker_open, .stop_with_cooling, .stop_immediate,
		.restart_inhibit);
	serial_master_model sm (.clock, .reg_write, .reg_addr, .reg_wdata);
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic step(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic reset();
		@(posedge clock);
		nrst <= 1'b0;
		anomaly_cause <= 4'h0;
		unload_ramp_done <= 1'b0;
		step(2);
		nrst <= 1'b1;
		step(3);
	endtask
	task automatic raise(input logic [3:0] c);
		anomaly_cause <= c;
		step(3);
		anomaly_cause <= 4'h0;
		step(3);
	endtask
	task automatic press();
		panel_ack_button <= 1'b1;
		step(6);
		panel_ack_button <= 1'b0;
		step(6);
	endtask
	task automatic cmd(input logic [15:0] pw, input logic [15:0] code, input int gap);
		sm.command(pw, code, gap);
		step(3);
	endtask
	task automatic wrap_up();
		if (mismatches == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		for (int i = 0; i < 4; i++) begin
			reset();
			raise(rows[i][15:12]);
			chk(active_classes, rows[i][11:8]);
			chk(acts, rows[i][7:4]);
			chk(snd, rows[i][3:0]);
			// Two looks half a flash period apart: warning toggles, others stay lit
			lamp0 = alarm_lamp;
			step(4);
			lamp_seen = {2'h0, alarm_lamp | lamp0, alarm_lamp ^ lamp0};
			chk(lamp_seen, {2'h0, 1'b1, rows[i][12]});
		end
		// Higher class active blocks lower ones until bypass
		reset();
		anomaly_cause <= 4'h8;
		step(3);
		anomaly_cause <= 4'h7;
		step(3);
		chk(active_classes, 4'h8);
		priority_bypass <= 1'b1;
		step(3);
		chk(active_classes, 4'hf);
		priority_bypass <= 1'b0;
		// Unload ramp end, then serial commands: bad password, disabled, silence, late, acknowledge
		reset();
		raise(4'h2);
		unload_ramp_done <= 1'b1;
		step(3);
		chk(acts, 4'h6);
		cmd(16'h1234, anomaly_pkg::CMD_ACKNOWLEDGE, 0);
		chk(unacked_classes, 4'h2);
		serial_command_disable_input <= 1'b1;
		step(6);
		cmd(16'h5a5a, anomaly_pkg::CMD_ACKNOWLEDGE, 0);
		chk(unacked_classes, 4'h2);
		serial_command_disable_input <= 1'b0;
		step(6);
		cmd(16'h5a5a, anomaly_pkg::CMD_SILENCE, 0);
		chk(snd, 4'h1);
		cmd(16'h5a5a, anomaly_pkg::CMD_ACKNOWLEDGE, 210);
		chk(unacked_classes, 4'h2);
		cmd(16'h5a5a, anomaly_pkg::CMD_ACKNOWLEDGE, 0);
		chk(unacked_classes, 4'h0);
		chk(active_classes, 4'h2);
		// Panel: first press silences, second acknowledges
		reset();
		raise(4'h1);
		press();
		chk(snd, 4'h0);
		chk(unacked_classes, 4'h1);
		press();
		chk(active_classes, 4'h0);
		// Held acknowledge input does nothing until a new edge
		reset();
		alarm_ack_input_function <= 1'b1;
		step(6);
		raise(4'h1);
		chk(unacked_classes, 4'h1);
		alarm_ack_input_function <= 1'b0;
		step(6);
		alarm_ack_input_function <= 1'b1;
		step(6);
		chk(unacked_classes, 4'h0);
		// Drop the input so the next reset does not see a held level as an edge
		alarm_ack_input_function <= 1'b0;
		// Timed horn restarted by a second class, then never
		horn_duration <= 10'h003;
		reset();
		anomaly_cause <= 4'h1;
		step(20);
		anomaly_cause <= 4'h3;
		step(20);
		chk(snd, 4'h3);
		anomaly_cause <= 4'h0;
		step(20);
		chk(snd, 4'h1);
		horn_duration <= 10'h000;
		reset();
		raise(4'h1);
		chk(snd, 4'h0);
		wrap_up();
	end
endmodule // anomaly_alarm_manager_bench
